// ===== hw/afe_ctrl_pkg.sv
// package for the voice and audio front end control bank
// assumes an apb slave with byte addresses on a 12-bit window
package afe_ctrl_pkg;

  localparam logic [11:0] voice_gain_control_off     = 12'h100;
  localparam logic [11:0] voice_circuit_control0_off = 12'h104;
  localparam logic [11:0] voice_circuit_control1_off = 12'h108;
  localparam logic [11:0] voice_power_control_off    = 12'h10c;
  localparam logic [11:0] voice_agc_control_off      = 12'h110;
  localparam logic [11:0] audio_gain_control_off     = 12'h200;
  localparam logic [11:0] audio_circuit_control_off  = 12'h204;
  localparam logic [11:0] audio_power_control_off    = 12'h208;
  localparam logic [11:0] audio_enhanced_control_off = 12'h20c;

  // masks of the implemented bits; everything else reads as zero
  localparam logic [15:0] voice_gain_mask   = 16'h01ff;
  localparam logic [15:0] voice_circ0_mask  = 16'hffff;
  localparam logic [15:0] voice_circ1_mask  = 16'hff83;
  localparam logic [15:0] voice_power_mask  = 16'h003d;
  localparam logic [15:0] voice_agc_mask    = 16'h7fff;
  localparam logic [15:0] audio_gain_mask   = 16'h03ff;
  localparam logic [15:0] audio_circ_mask   = 16'h37ff;
  localparam logic [15:0] audio_power_mask  = 16'h001f;
  localparam logic [15:0] audio_enh_mask    = 16'h01ff;

  localparam logic [15:0] voice_gain_rst   = 16'h0000;
  localparam logic [15:0] voice_circ0_rst  = 16'h0000;
  localparam logic [15:0] voice_circ1_rst  = 16'h0200;
  localparam logic [15:0] voice_power_rst  = 16'h0000;
  localparam logic [15:0] voice_agc_rst    = 16'h0000;
  localparam logic [15:0] audio_gain_rst   = 16'h0000;
  localparam logic [15:0] audio_circ_rst   = 16'h0000;
  localparam logic [15:0] audio_power_rst  = 16'h0000;
  localparam logic [15:0] audio_enh_rst    = 16'h0000;

  localparam logic [1:0] src_input0 = 2'h0;
  localparam logic [1:0] src_input1 = 2'h1;
  localparam logic [11:0] mic_bias_base_mv = 12'h76c;

  typedef struct packed {
    logic [6:0] pad;
    logic [4:0] uplink_gain;
    logic [3:0] downlink_gain0;
  } voice_gain_t;

  typedef struct packed {
    logic       voice_dc_sense_en;
    logic       mic_neg_bias_short;
    logic [1:0] mic_bias_level;
    logic       mic_single_ended;
    logic       atten_mode;
    logic       dc_coupling;
    logic [1:0] uplink_src;
    logic [1:0] out0_single_ended;
    logic [4:0] voice_bias_trim;
  } voice_circ0_t;

  typedef struct packed {
    logic       voice_depop_en;
    logic       downlink_bias_boost;
    logic       downlink_overcurrent_en;
    logic [2:0] bandgap_ctrl;
    logic       downlink_dac_bias_sel;
    logic       voice_output_float;
    logic       signed_digit_mode;
    logic [4:0] pad;
    logic       adc_loopback_mode;
    logic       dac_loopback_mode;
  } voice_circ1_t;

  typedef struct packed {
    logic [9:0] pad;
    logic       voice_bias_power;
    logic       voice_lna_power;
    logic       voice_adc_power;
    logic       voice_dac_power;
    logic       pad1;
    logic       voice_out0_power;
  } voice_power_t;

  typedef struct packed {
    logic       pad;
    logic       analog_agc_en;
    logic       agc_test;
    logic [1:0] agc_noise_duration_sel;
    logic [1:0] agc_noise_level_sel;
    logic [1:0] agc_fast_release_sel;
    logic [1:0] agc_slow_release_sel;
    logic [1:0] agc_attack_thresh_cal;
    logic       agc_attack_clock_sel;
    logic       agc_hysteresis_en;
    logic       digital_agc_en;
  } voice_agc_t;

  typedef struct packed {
    logic [5:0] pad;
    logic       audio_mute_first;
    logic       audio_mute_second;
    logic [3:0] audio_gain_right;
    logic [3:0] audio_gain_left;
  } audio_gain_t;

  typedef struct packed {
    logic [1:0] pad;
    logic       audio_short_protect_en;
    logic       audio_depop_en;
    logic       pad1;
    logic [2:0] audio_buffer_src_right;
    logic [2:0] audio_buffer_src_left;
    logic [4:0] audio_bias_trim;
  } audio_circ_t;

  typedef struct packed {
    logic [10:0] pad;
    logic        audio_bias_power;
    logic        audio_right_dac_power;
    logic        audio_left_dac_power;
    logic        audio_right_out_power;
    logic        audio_left_out_power;
  } audio_power_t;

  typedef struct packed {
    logic [6:0] pad;
    logic       enh_mic_short;
    logic [1:0] buffer_bias_sel;
    logic       old_dac_sel;
    logic [1:0] output_mux_sel;
    logic       common_mode_buffer_en;
    logic       common_mode_circuit_sel;
    logic       enh_dc_couple;
  } audio_enh_t;

  // decoded levels, gains in signed db and bias in millivolts
  typedef struct packed {
    logic signed [7:0] uplink_gain_db;
    logic signed [7:0] downlink_gain0_db;
    logic              uplink_atten_active;
    logic [11:0]       mic_bias_mv;
    logic              uplink_src_reserved;
    logic signed [7:0] audio_right_db;
    logic signed [7:0] audio_left_db;
    logic              right_src_reserved;
    logic              left_src_reserved;
    logic              output_mux_fm;
  } afe_decoded_t;

  typedef struct packed {
    voice_gain_t  vgain;
    voice_circ0_t vcirc0;
    voice_circ1_t vcirc1;
    voice_power_t vpower;
    voice_agc_t   vagc;
    audio_gain_t  again;
    audio_circ_t  acirc;
    audio_power_t apower;
    audio_enh_t   aenh;
  } afe_regs_t;

endpackage

// ===== hw/afe_ctrl.sv
// apb register bank holding the static controls of the voice and
// audio analog front ends, plus registered decoded gain levels
// assumes a single clock domain shared with the apb master
`timescale 1ns/1ps

// Operation
// - amplification mode uplink gain is 2 db steps from -20 db to 42 db
// - attenuation mode uses low three bits, 3 db steps down to -21 db
// - downlink gain 0 maps 2 db steps from -22 db to 8 db
// - mic bias level codes give 1.9, 2.0, 2.1 or 2.2 volts
// - voice config low bits pick input 0, input 1, fm, reserved
// - config bit 4 picks single-ended biasing, bit 2 picks dc coupling
// - config bit 3 selects attenuation, only effective for input 1
// - short bit ties negative bias to ground, otherwise to positive bias
// - dc sense bit enables dc coupled microphone sensing
// - loopback bits feed adc from dac or dac from adc
// - downlink buffer enables single bits; dac bias select resets to 1
// - signed digit bit picks 3-level modulator; float bit floats driver
// - voice power bits power up each block when 1, reset to 0
// - hysteresis enable bit; attack clock select 16 or 32 khz
// - slow and fast release clock fields select four rates each
// - noise level and noise duration fields select four values each
// - audio channel gain table -22 db to 23 db with mute bits
// - audio buffer source select codes; other codes are reserved
// - audio power bits power up bias, dacs and output buffers
// - enhanced register picks dac and common mode circuit, output mux
module afe_ctrl (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic [11:0]                paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  output afe_ctrl_pkg::afe_regs_t         regs,
  output afe_ctrl_pkg::afe_decoded_t      decoded
);

  typedef struct packed {
    afe_ctrl_pkg::afe_regs_t    regs;
    afe_ctrl_pkg::afe_decoded_t dec;
    logic [31:0]                rdata;
    logic                       ready;
    logic                       err;
  } state_t;

  state_t st_q;
  state_t st_d;

  function automatic logic signed [7:0] uplink_db(input logic [4:0] code,
                                                  input logic       atten);
    logic [7:0] c;
    c = {3'h0, code};
    if (atten) begin
      uplink_db = 8'h00 - ({5'h00, c[2:0]} + {4'h0, c[2:0], 1'b0});
    end else begin
      uplink_db = {c[6:0], 1'b0} - 8'h14;
    end
  endfunction

  function automatic logic signed [7:0] audio_db(input logic [3:0] code);
    unique case (code)
      4'hf: audio_db = 8'h17;
      4'he: audio_db = 8'h14;
      4'hd: audio_db = 8'h11;
      4'hc: audio_db = 8'h0e;
      4'hb: audio_db = 8'h0d;
      4'ha: audio_db = 8'h08;
      4'h9: audio_db = 8'h05;
      4'h8: audio_db = 8'h02;
      4'h7: audio_db = 8'hff;
      4'h6: audio_db = 8'hfc;
      4'h5: audio_db = 8'hf9;
      4'h4: audio_db = 8'hf6;
      4'h3: audio_db = 8'hf3;
      4'h2: audio_db = 8'hf0;
      4'h1: audio_db = 8'hed;
      4'h0: audio_db = 8'hea;
    endcase
  endfunction

  function automatic logic src_reserved(input logic [2:0] code);
    src_reserved = (code == 3'h3) || (code > 3'h5);
  endfunction

  function automatic logic [15:0] wmask(input logic [31:0] d,
                                        input logic [15:0] m);
    wmask = d[15:0] & m;
  endfunction

  logic        setup;
  logic        wr;
  logic        hit;
  logic [15:0] rd;

  always_comb begin
    st_d  = st_q;
    setup = psel && !penable;
    wr    = psel && penable && pwrite;
    hit   = 1'b1;
    rd    = 16'h0000;
    unique case (paddr)
      afe_ctrl_pkg::voice_gain_control_off:     rd = st_q.regs.vgain;
      afe_ctrl_pkg::voice_circuit_control0_off: rd = st_q.regs.vcirc0;
      afe_ctrl_pkg::voice_circuit_control1_off: rd = st_q.regs.vcirc1;
      afe_ctrl_pkg::voice_power_control_off:    rd = st_q.regs.vpower;
      afe_ctrl_pkg::voice_agc_control_off:      rd = st_q.regs.vagc;
      afe_ctrl_pkg::audio_gain_control_off:     rd = st_q.regs.again;
      afe_ctrl_pkg::audio_circuit_control_off:  rd = st_q.regs.acirc;
      afe_ctrl_pkg::audio_power_control_off:    rd = st_q.regs.apower;
      afe_ctrl_pkg::audio_enhanced_control_off: rd = st_q.regs.aenh;
      default:                                  hit = 1'b0;
    endcase

    // answer one cycle after setup so the access phase sees ready
    st_d.ready = setup;
    st_d.err   = setup && !hit;
    if (setup) begin
      st_d.rdata = {16'h0000, rd};
    end

    // unmapped writes are dropped and flagged through pslverr
    if (wr && hit) begin
      unique case (paddr)
        afe_ctrl_pkg::voice_gain_control_off:
          st_d.regs.vgain = afe_ctrl_pkg::voice_gain_t'(
            wmask(pwdata, afe_ctrl_pkg::voice_gain_mask));
        afe_ctrl_pkg::voice_circuit_control0_off:
          st_d.regs.vcirc0 = afe_ctrl_pkg::voice_circ0_t'(
            wmask(pwdata, afe_ctrl_pkg::voice_circ0_mask));
        afe_ctrl_pkg::voice_circuit_control1_off:
          st_d.regs.vcirc1 = afe_ctrl_pkg::voice_circ1_t'(
            wmask(pwdata, afe_ctrl_pkg::voice_circ1_mask));
        afe_ctrl_pkg::voice_power_control_off:
          st_d.regs.vpower = afe_ctrl_pkg::voice_power_t'(
            wmask(pwdata, afe_ctrl_pkg::voice_power_mask));
        afe_ctrl_pkg::voice_agc_control_off:
          st_d.regs.vagc = afe_ctrl_pkg::voice_agc_t'(
            wmask(pwdata, afe_ctrl_pkg::voice_agc_mask));
        afe_ctrl_pkg::audio_gain_control_off:
          st_d.regs.again = afe_ctrl_pkg::audio_gain_t'(
            wmask(pwdata, afe_ctrl_pkg::audio_gain_mask));
        afe_ctrl_pkg::audio_circuit_control_off:
          st_d.regs.acirc = afe_ctrl_pkg::audio_circ_t'(
            wmask(pwdata, afe_ctrl_pkg::audio_circ_mask));
        afe_ctrl_pkg::audio_power_control_off:
          st_d.regs.apower = afe_ctrl_pkg::audio_power_t'(
            wmask(pwdata, afe_ctrl_pkg::audio_power_mask));
        afe_ctrl_pkg::audio_enhanced_control_off:
          st_d.regs.aenh = afe_ctrl_pkg::audio_enh_t'(
            wmask(pwdata, afe_ctrl_pkg::audio_enh_mask));
        default: ;
      endcase
    end

    // decoded levels follow the registers on the same edge
    st_d.dec.uplink_atten_active =
      st_d.regs.vcirc0.atten_mode &&
      (st_d.regs.vcirc0.uplink_src == afe_ctrl_pkg::src_input1);
    st_d.dec.uplink_gain_db = uplink_db(st_d.regs.vgain.uplink_gain,
                                        st_d.dec.uplink_atten_active);
    st_d.dec.downlink_gain0_db =
      {3'h0, st_d.regs.vgain.downlink_gain0, 1'b0} - 8'h16;
    // widen before the product: 3 * 100 would wrap at the code's width
    st_d.dec.mic_bias_mv = afe_ctrl_pkg::mic_bias_base_mv +
      ({10'h000, st_d.regs.vcirc0.mic_bias_level} * 12'h064);
    st_d.dec.uplink_src_reserved =
      (st_d.regs.vcirc0.uplink_src == 2'h3);
    st_d.dec.audio_right_db = audio_db(st_d.regs.again.audio_gain_right);
    st_d.dec.audio_left_db  = audio_db(st_d.regs.again.audio_gain_left);
    st_d.dec.right_src_reserved =
      src_reserved(st_d.regs.acirc.audio_buffer_src_right);
    st_d.dec.left_src_reserved =
      src_reserved(st_d.regs.acirc.audio_buffer_src_left);
    st_d.dec.output_mux_fm = !st_d.regs.aenh.output_mux_sel[1];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q.regs.vgain  <= afe_ctrl_pkg::voice_gain_t'(
                            afe_ctrl_pkg::voice_gain_rst);
      st_q.regs.vcirc0 <= afe_ctrl_pkg::voice_circ0_t'(
                            afe_ctrl_pkg::voice_circ0_rst);
      st_q.regs.vcirc1 <= afe_ctrl_pkg::voice_circ1_t'(
                            afe_ctrl_pkg::voice_circ1_rst);
      st_q.regs.vpower <= afe_ctrl_pkg::voice_power_t'(
                            afe_ctrl_pkg::voice_power_rst);
      st_q.regs.vagc   <= afe_ctrl_pkg::voice_agc_t'(
                            afe_ctrl_pkg::voice_agc_rst);
      st_q.regs.again  <= afe_ctrl_pkg::audio_gain_t'(
                            afe_ctrl_pkg::audio_gain_rst);
      st_q.regs.acirc  <= afe_ctrl_pkg::audio_circ_t'(
                            afe_ctrl_pkg::audio_circ_rst);
      st_q.regs.apower <= afe_ctrl_pkg::audio_power_t'(
                            afe_ctrl_pkg::audio_power_rst);
      st_q.regs.aenh   <= afe_ctrl_pkg::audio_enh_t'(
                            afe_ctrl_pkg::audio_enh_rst);
      // decoded values of the all-zero reset codes
      st_q.dec.uplink_gain_db      <= 8'hec;
      st_q.dec.downlink_gain0_db   <= 8'hea;
      st_q.dec.uplink_atten_active <= 1'b0;
      st_q.dec.mic_bias_mv         <= afe_ctrl_pkg::mic_bias_base_mv;
      st_q.dec.uplink_src_reserved <= 1'b0;
      st_q.dec.audio_right_db      <= 8'hea;
      st_q.dec.audio_left_db       <= 8'hea;
      st_q.dec.right_src_reserved  <= 1'b0;
      st_q.dec.left_src_reserved   <= 1'b0;
      st_q.dec.output_mux_fm       <= 1'b1;
      st_q.rdata                   <= 32'h0000_0000;
      st_q.ready                   <= 1'b0;
      st_q.err                     <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata  = st_q.rdata;
  assign pready  = st_q.ready;
  assign pslverr = st_q.err;
  assign regs    = st_q.regs;
  assign decoded = st_q.dec;

endmodule

// ===== verif/afe_ctrl_sva.sv
// assertions for the voice and audio front end control bank
// assumes it is bound to afe_ctrl and sees only that module's ports
`timescale 1ns/1ps
module afe_ctrl_sva (
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire logic [11:0]                paddr,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [31:0]                pwdata,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire afe_ctrl_pkg::afe_regs_t    regs,
  input wire afe_ctrl_pkg::afe_decoded_t decoded
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  function automatic logic mapped(input logic [11:0] a);
    return a inside {12'h100, 12'h104, 12'h108, 12'h10c, 12'h110,
                     12'h200, 12'h204, 12'h208, 12'h20c};
  endfunction

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_power_write;
    psel && penable && pwrite && pready &&
      paddr == afe_ctrl_pkg::voice_power_control_off;
  endsequence

  property p_ready_pulse;
    s_setup |=> pready ##1 !pready;
  endproperty
  property p_err_unmapped;
    pready |-> pslverr == !mapped(paddr);
  endproperty
  property p_rdata_upper;
    pready |-> prdata[31:16] == 16'h0;
  endproperty
  // read data must track the stored word, not a stale copy
  property p_read_power;
    pready && !pwrite && paddr == afe_ctrl_pkg::voice_power_control_off
      |-> prdata[15:0] == regs.vpower;
  endproperty
  property p_power_commit;
    s_setup ##1 s_power_write |=>
      regs.vpower == ($past(pwdata[15:0]) & 16'h003d);
  endproperty
  property p_uplink_amp;
    !decoded.uplink_atten_active |-> int'($signed(decoded.uplink_gain_db))
      == 2 * int'(regs.vgain.uplink_gain) - 20;
  endproperty
  property p_uplink_att;
    decoded.uplink_atten_active |-> int'($signed(decoded.uplink_gain_db))
      == -3 * int'(regs.vgain.uplink_gain[2:0]);
  endproperty
  property p_att_only_input1;
    decoded.uplink_atten_active == (regs.vcirc0.atten_mode &&
      regs.vcirc0.uplink_src == afe_ctrl_pkg::src_input1);
  endproperty
  property p_downlink;
    int'($signed(decoded.downlink_gain0_db))
      == 2 * int'(regs.vgain.downlink_gain0) - 22;
  endproperty
  property p_mic_bias;
    int'(decoded.mic_bias_mv) == 1900 + 100 * int'(regs.vcirc0.mic_bias_level);
  endproperty
  property p_src_reserved;
    decoded.uplink_src_reserved == (regs.vcirc0.uplink_src == 2'h3);
  endproperty
  property p_mux_fm;
    decoded.output_mux_fm == !regs.aenh.output_mux_sel[1];
  endproperty

  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready not a single pulse after setup");
  a_err_unmapped: assert property (p_err_unmapped)
    else $error("error response does not match address map");
  a_rdata_upper: assert property (p_rdata_upper)
    else $error("upper read data not zero");
  a_read_power: assert property (p_read_power)
    else $error("power register read differs from stored value");
  a_power_commit: assert property (p_power_commit)
    else $error("power register write not committed");
  a_uplink_amp: assert property (p_uplink_amp)
    else $error("uplink amplification gain wrong");
  a_uplink_att: assert property (p_uplink_att)
    else $error("uplink attenuation gain wrong");
  a_att_only_input1: assert property (p_att_only_input1)
    else $error("attenuation active for wrong source");
  a_downlink: assert property (p_downlink)
    else $error("downlink gain wrong");
  a_mic_bias: assert property (p_mic_bias)
    else $error("mic bias level wrong");
  a_src_reserved: assert property (p_src_reserved)
    else $error("uplink reserved source flag wrong");
  a_mux_fm: assert property (p_mux_fm)
    else $error("output mux fm flag wrong");
endmodule

// ===== verif/voice_audio_frontend_control_tb.sv
// self-checking bench for the front end control bank
// assumes afe_ctrl_pkg and afe_ctrl are compiled first
`timescale 1ns/1ps
module voice_audio_frontend_control_tb;
  logic                       clk;
  logic                       rst_n;
  logic [11:0]                paddr;
  logic                       psel;
  logic                       penable;
  logic                       pwrite;
  logic [31:0]                pwdata;
  logic [31:0]                prdata;
  logic                       pready;
  logic                       pslverr;
  afe_ctrl_pkg::afe_regs_t    regs;
  afe_ctrl_pkg::afe_decoded_t decoded;
  int                         failures = 0;
  int                         compares = 0;
  int                         cycles = 0;
  logic [31:0]                rd;
  logic                       err;
  logic [15:0]                msk [9] = '{16'h01ff, 16'hffff, 16'hff83,
    16'h003d, 16'h7fff, 16'h03ff, 16'h37ff, 16'h001f, 16'h01ff};
  int                         adb [16] = '{-22, -19, -16, -13, -10, -7,
    -4, -1, 2, 5, 8, 13, 14, 17, 20, 23};

  afe_ctrl dut (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .regs(regs), .decoded(decoded));

  function automatic logic [11:0] off(input int i);
    return (i < 5) ? 12'(12'h100 + 4 * i) : 12'(12'h200 + 4 * (i - 5));
  endfunction
  function automatic logic [31:0] sx(input logic [7:0] v);
    return {{24{v[7]}}, v};
  endfunction

  task automatic report_and_stop;
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one zero-wait transfer; data taken while ready stands before its edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    psel = 1'b1;
    penable = 1'b0;
    pwrite = w;
    paddr = a;
    pwdata = {16'h0, d};
    @(negedge clk);
    penable = 1'b1;
    while (pready !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    if (n == 8) chk(32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    @(negedge clk);
    psel = 1'b0;
    penable = 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // whole run is a few hundred cycles; this only cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, off(i), 16'h0);
      chk(rd, (i == 2) ? 32'h0200 : 32'h0);
    end
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, off(i), 16'hffff);
      apb(1'b0, off(i), 16'h0);
      chk(rd, {16'h0, msk[i]});
      apb(1'b1, off(i), 16'h5a5a);
      apb(1'b0, off(i), 16'h0);
      chk(rd, {16'h0, msk[i] & 16'h5a5a});
    end
    apb(1'b1, 12'h114, 16'hffff);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 12'h114, 16'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, off(3), 16'h003d);
    chk({16'h0, regs.vpower}, 32'h003d);
    apb(1'b1, off(2), 16'h0280);
    chk({16'h0, regs.vcirc1}, 32'h0280);
    chk({31'h0, regs.vcirc1.downlink_dac_bias_sel}, 32'h1);
    chk({31'h0, regs.vcirc1.signed_digit_mode}, 32'h1);
    apb(1'b1, off(4), 16'h4dcf);
    chk({30'h0, regs.vagc.digital_agc_en,
         regs.vagc.analog_agc_en}, 32'h3);
    chk({31'h0, regs.vagc.agc_attack_clock_sel}, 32'h1);
    apb(1'b1, off(7), 16'h00ff);
    chk({16'h0, regs.apower}, 32'h001f);
    apb(1'b1, off(1), 16'h0000);
    for (int i = 0; i < 32; i++) begin
      apb(1'b1, off(0), {7'h0, 5'(i), 4'(i)});
      chk(sx(decoded.uplink_gain_db), 32'(2 * i - 20));
      chk(sx(decoded.downlink_gain0_db), 32'(2 * (i % 16) - 22));
    end
    // upper code bits set on purpose: attenuation must ignore them
    apb(1'b1, off(1), 16'h0480);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, off(0), {7'h0, 2'h3, 3'(i), 4'h0});
      chk(sx(decoded.uplink_gain_db), 32'(-3 * i));
    end
    apb(1'b1, off(1), 16'h0400);
    chk({31'h0, decoded.uplink_atten_active}, 32'h0);
    chk(sx(decoded.uplink_gain_db), 32'(2 * 31 - 20));
    apb(1'b1, off(1), 16'h0180);
    chk({31'h0, decoded.uplink_src_reserved}, 32'h1);
    apb(1'b1, off(1), 16'h0100);
    chk({31'h0, decoded.uplink_src_reserved}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, off(1), 16'(i << 12));
      chk({20'h0, decoded.mic_bias_mv}, 32'(1900 + 100 * i));
    end
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, off(5), 16'(i * 16 + 15 - i));
      chk(sx(decoded.audio_right_db), 32'(adb[i]));
      chk(sx(decoded.audio_left_db), 32'(adb[15 - i]));
    end
    apb(1'b1, off(5), 16'h0200);
    chk({30'h0, regs.again.audio_mute_first,
         regs.again.audio_mute_second}, 32'h2);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, off(6), 16'((i << 8) | ((7 - i) << 5)));
      chk({31'h0, decoded.right_src_reserved},
          32'(i == 3 || i > 5));
      chk({31'h0, decoded.left_src_reserved},
          32'(i == 4 || i < 2));
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, off(8), 16'(i << 3));
      chk({31'h0, decoded.output_mux_fm}, 32'(i < 2));
    end
    // single control bits land at their own positions
    apb(1'b1, off(1), 16'h8a00);
    chk({31'h0, regs.vcirc0.voice_dc_sense_en}, 32'h1);
    chk({31'h0, regs.vcirc0.mic_neg_bias_short}, 32'h0);
    chk({30'h0, regs.vcirc0.mic_single_ended,
         regs.vcirc0.dc_coupling}, 32'h3);
    apb(1'b1, off(1), 16'h4000);
    chk({31'h0, regs.vcirc0.mic_neg_bias_short}, 32'h1);
    chk({31'h0, regs.vcirc0.voice_dc_sense_en}, 32'h0);
    chk({30'h0, regs.vcirc0.mic_single_ended,
         regs.vcirc0.dc_coupling}, 32'h0);
    apb(1'b1, off(2), 16'he102);
    chk({29'h0, regs.vcirc1.voice_depop_en, regs.vcirc1.downlink_bias_boost,
         regs.vcirc1.downlink_overcurrent_en}, 32'h7);
    chk({31'h0, regs.vcirc1.downlink_dac_bias_sel}, 32'h0);
    chk({31'h0, regs.vcirc1.voice_output_float}, 32'h1);
    chk({31'h0, regs.vcirc1.signed_digit_mode}, 32'h0);
    chk({30'h0, regs.vcirc1.adc_loopback_mode,
         regs.vcirc1.dac_loopback_mode}, 32'h2);
    apb(1'b1, off(2), 16'h0001);
    chk({30'h0, regs.vcirc1.adc_loopback_mode,
         regs.vcirc1.dac_loopback_mode}, 32'h1);
    apb(1'b1, off(4), 16'h1c82);
    chk({30'h0, regs.vagc.agc_hysteresis_en,
         regs.vagc.agc_attack_clock_sel}, 32'h2);
    chk({28'h0, regs.vagc.agc_fast_release_sel,
         regs.vagc.agc_slow_release_sel}, 32'h4);
    chk({28'h0, regs.vagc.agc_noise_duration_sel,
         regs.vagc.agc_noise_level_sel}, 32'he);
    apb(1'b1, off(8), 16'h0022);
    chk({30'h0, regs.aenh.old_dac_sel,
         regs.aenh.common_mode_circuit_sel}, 32'h3);
    chk({31'h0, decoded.output_mux_fm}, 32'h1);
    report_and_stop();
  end
endmodule

bind afe_ctrl afe_ctrl_sva chk (.clk(clk), .rst_n(rst_n), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .regs(regs),
  .decoded(decoded));
